// ### rtl/flash_access_pkg.sv
// shared constants, types and state records for the flash access guard
package flash_access_pkg;

   // link framing
   localparam int FRAME_BITS = 32;
   localparam int REPLY_BITS = 8;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] LAST_FRAME_BIT = CNT_W'(FRAME_BITS - 1);
   localparam logic [CNT_W-1:0] LAST_REPLY_BIT = CNT_W'(REPLY_BITS - 1);

   // address map and sector layout
   localparam logic [16:0] ADDR_SPAN = 17'h10000;
   localparam int KBYTE = 1024;
   localparam int SIZE_4K = 4;
   localparam int SIZE_8K = 8;
   localparam logic [15:0] SECTOR0_BASE = 16'hf000;
   localparam logic [15:0] SECTOR1_BASE = 16'he000;
   localparam logic [1:0] SECTOR_VECT = 2'h0;
   localparam logic [1:0] SECTOR_SECOND = 2'h1;
   localparam logic [1:0] SECTOR_REST = 2'h2;

   // option byte, unlock keys, reply codes
   localparam int OPT_PROTECT_POS = 0;
   localparam logic [7:0] KEY_FIRST = 8'ha5;
   localparam logic [7:0] KEY_SECOND = 8'h5a;
   localparam logic [7:0] RPL_OK = 8'h00;
   localparam logic [7:0] RPL_DENIED = 8'he1;
   localparam logic [7:0] RPL_LOCKED = 8'he2;
   localparam logic [7:0] RPL_BAD = 8'he3;
   localparam logic [4:0] CMD_HIGH_ZERO = 5'h00;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0, OP_READ = 3'h1, OP_PROGRAM = 3'h2, OP_ERASE_SECTOR = 3'h3,
      OP_ERASE_ALL = 3'h4, OP_OPTION = 3'h5, OP_UNLOCK = 3'h6
   } op_kind_e;

   typedef enum logic [2:0] {MODE_OFFBOARD = 3'b001, MODE_ICP = 3'b010, MODE_IAP = 3'b100} prog_mode_e;
   typedef enum logic [2:0] {LOCK_CLOSED = 3'b001, LOCK_HALF = 3'b010, LOCK_OPEN = 3'b100} lock_e;
   typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_WAIT = 3'b010, ST_WIPE = 3'b100} sys_state_e;
   typedef enum logic [3:0] {
      LS_SHIFT = 4'b0001, LS_WAIT = 4'b0010, LS_REPLY = 4'b0100, LS_DONE = 4'b1000
   } link_state_e;

   typedef struct packed {
      op_kind_e kind;
      logic [15:0] addr;
      logic [7:0] data;
   } flash_op_s;

   typedef struct packed {
      logic [7:0] cmd;
      logic [15:0] addr;
      logic [7:0] data;
   } link_frame_s;

   typedef struct packed {
      logic sel_meta;
      logic sel_sync;
      logic strap_meta;
      logic strap_sync;
      prog_mode_e mode;
      logic prot;
      sys_state_e state;
      lock_e lock;
      logic req_last;
      logic ack_tgl;
      logic [7:0] reply;
      logic src_link;
      flash_op_s op;
      logic stb;
      logic [7:0] pend;
      logic iap_done;
      logic [7:0] iap_status;
   } sys_regs_s;

   typedef struct packed {
      link_state_e state;
      logic [CNT_W-1:0] cnt;
      logic [FRAME_BITS-1:0] shift;
      link_frame_s frame;
      logic req_tgl;
      logic [7:0] rsh;
      logic dout;
      logic oe;
   } link_regs_s;

endpackage : flash_access_pkg

// ### rtl/bit_sync.sv
// two-stage synchroniser for levels entering a clock domain
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge clock) begin
      meta_r <= async_in;
      sync_out <= meta_r;
   end
endmodule : bit_sync
`default_nettype wire

// ### rtl/flash_access_guard.sv
// sector access and read-out protection guard for the program flash
`timescale 1ns/100ps
`default_nettype none
// Function
// - erase whole or per sector, program bytes
// - tool and in-circuit modes reach all sectors
// - in-application mode never programs or erases sector zero
// - sector count follows flash size
// - sectors zero, one fixed 4K at top
// - sector erase leaves other sectors intact
// - protection blocks external reads and writes
// - removing protection first erases whole array
// - option byte bit selects read-out protection
// - link uses clock, data, select pins
module flash_access_guard import flash_access_pkg::*; #(
   parameter int FLASH_KBYTES = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic offboard_strap,
   input wire logic prog_link_clock,
   input wire logic prog_select_vpp,
   input wire logic prog_link_data_in,
   output logic prog_link_data_out,
   output logic prog_link_data_oe,
   input wire logic iap_valid,
   input wire flash_op_s iap_op,
   output logic iap_done,
   output logic [7:0] iap_status,
   output logic flash_stb,
   output flash_op_s flash_op,
   input wire logic flash_done,
   input wire logic [7:0] flash_rdata,
   input wire logic [7:0] option_byte,
   output prog_mode_e prog_mode,
   output logic readout_protected
);
   // lowest mapped address; sector count follows from it
   localparam logic [16:0] FLASH_BASE = 17'(ADDR_SPAN - FLASH_KBYTES * KBYTE);

   sys_regs_s r, n;
   link_regs_s l, m;
   logic req_sync;
   logic [1:0] link_in;
   logic ack_l, lrst;
   logic link_new;
   logic finish, src;
   logic [7:0] code;
   flash_op_s req, link_op;

   // sector index of an address
   function automatic logic [1:0] sector_of(input logic [15:0] a);
      if (a >= SECTOR0_BASE) begin
         sector_of = SECTOR_VECT;
      end else if (a >= SECTOR1_BASE) begin
         sector_of = SECTOR_SECOND;
      end else begin
         sector_of = SECTOR_REST;
      end
   endfunction : sector_of

   // first address of a sector
   function automatic logic [15:0] sector_base(input logic [1:0] s);
      case (s)
         SECTOR_VECT: sector_base = SECTOR0_BASE;
         SECTOR_SECOND: sector_base = SECTOR1_BASE;
         default: sector_base = FLASH_BASE[15:0];
      endcase
   endfunction : sector_base

   // unpack a link frame into an operation
   function automatic flash_op_s frame_to_op(input link_frame_s f);
      frame_to_op.addr = f.addr;
      frame_to_op.data = f.data;
      if (f.cmd[7:3] == CMD_HIGH_ZERO && f.cmd[2:0] <= OP_UNLOCK) begin
         frame_to_op.kind = op_kind_e'(f.cmd[2:0]);
      end else begin
         frame_to_op.kind = OP_NONE;
      end
   endfunction : frame_to_op

   // mode, range and protection check
   function automatic logic permitted(input flash_op_s op, input prog_mode_e mode, input logic prot,
                                      input logic ext);
      logic touch;
      touch = (op.kind == OP_READ) || (op.kind == OP_PROGRAM) || (op.kind == OP_ERASE_SECTOR);
      permitted = 1'b1;
      if (touch && {1'b0, op.addr} < FLASH_BASE) begin
         permitted = 1'b0;
      end
      if (mode == MODE_IAP && (op.kind == OP_ERASE_ALL || op.kind == OP_OPTION)) begin
         permitted = 1'b0;
      end
      if (mode == MODE_IAP && op.kind != OP_READ && touch && sector_of(op.addr) == SECTOR_VECT) begin
         permitted = 1'b0;
      end
      if (ext && prot && touch) begin
         permitted = 1'b0;
      end
   endfunction : permitted

   // crossings: request toggle into system, ack toggle and reset into link
   bit_sync #(.WIDTH(1)) req_cross (.clock(clock), .async_in(l.req_tgl), .sync_out(req_sync));
   bit_sync #(.WIDTH(2)) link_cross (.clock(prog_link_clock), .async_in({r.ack_tgl, rst}), .sync_out(link_in));
   assign ack_l = link_in[1];
   assign lrst = link_in[0];

   // frame word is held stable by the link until its reply is sent
   assign link_op = frame_to_op(l.frame);
   assign link_new = (req_sync != r.req_last);

   // system-side decision and sequencing
   always_comb begin
      n = r;
      n.sel_meta = prog_select_vpp;
      n.sel_sync = r.sel_meta;
      n.strap_meta = offboard_strap;
      n.strap_sync = r.strap_meta;
      n.mode = r.strap_sync ? MODE_OFFBOARD : (r.sel_sync ? MODE_ICP : MODE_IAP);
      n.prot = option_byte[OPT_PROTECT_POS];
      n.stb = 1'b0;
      n.iap_done = 1'b0;
      finish = 1'b0;
      code = RPL_OK;
      req = link_new ? link_op : iap_op;
      case (r.state)
         ST_IDLE: begin
            if (link_new || (iap_valid && !r.iap_done && r.mode == MODE_IAP)) begin
               n.src_link = link_new;
               if (link_new) begin
                  n.req_last = req_sync;
               end
               finish = 1'b1;
               if (req.kind == OP_NONE) begin
                  code = RPL_BAD;
               end else if (link_new && r.mode == MODE_IAP) begin
                  code = RPL_DENIED;
               end else if (req.kind == OP_UNLOCK) begin
                  if (r.lock == LOCK_CLOSED && req.data == KEY_FIRST) begin
                     n.lock = LOCK_HALF;
                  end else if (r.lock == LOCK_HALF && req.data == KEY_SECOND) begin
                     n.lock = LOCK_OPEN;
                  end else begin
                     n.lock = LOCK_CLOSED;
                     code = RPL_BAD;
                  end
               end else if (!permitted(req, r.mode, r.prot, link_new)) begin
                  code = RPL_DENIED;
               end else if (req.kind != OP_READ && r.lock != LOCK_OPEN) begin
                  code = RPL_LOCKED;
               end else begin
                  finish = 1'b0;
                  n.stb = 1'b1;
                  n.op = req;
                  n.state = ST_WAIT;
                  if (req.kind != OP_READ) begin
                     n.lock = LOCK_CLOSED;
                  end
                  if (req.kind == OP_ERASE_SECTOR) begin
                     n.op.addr = sector_base(sector_of(req.addr));
                  end
                  if (req.kind == OP_OPTION && r.prot && !req.data[OPT_PROTECT_POS]) begin
                     n.op.kind = OP_ERASE_ALL;
                     n.pend = req.data;
                     n.state = ST_WIPE;
                  end
               end
            end
         end
         ST_WIPE: begin
            if (flash_done) begin
               n.stb = 1'b1;
               n.op.kind = OP_OPTION;
               n.op.data = r.pend;
               n.state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (flash_done) begin
               finish = 1'b1;
               code = (r.op.kind == OP_READ) ? flash_rdata : RPL_OK;
               n.state = ST_IDLE;
            end
         end
         default: begin
            n.state = ST_IDLE;
         end
      endcase
      src = (r.state == ST_IDLE) ? link_new : r.src_link;
      // answer to link (held reply and toggle, set in the same cycle) or to application
      if (finish && src) begin
         n.reply = code;
         n.ack_tgl = ~r.ack_tgl;
      end else if (finish) begin
         n.iap_done = 1'b1;
         n.iap_status = code;
      end
   end

   // system state register
   always_ff @(posedge clock) begin
      if (rst) begin
         r <= '0;
         r.mode <= MODE_IAP;
         r.state <= ST_IDLE;
         r.lock <= LOCK_CLOSED;
         r.op.kind <= OP_NONE;
      end else begin
         r <= n;
      end
   end

   // link-side shifter: 32 bits in, wait, start bit, 8 bits out
   always_comb begin
      m = l;
      if (lrst) begin
         m = '0;
         m.state = LS_SHIFT;
      end else if (!prog_select_vpp) begin
         m.state = LS_SHIFT;
         m.cnt = '0;
         m.oe = 1'b0;
         m.dout = 1'b0;
      end else begin
         case (l.state)
            LS_SHIFT: begin
               m.shift = {l.shift[FRAME_BITS-2:0], prog_link_data_in};
               m.cnt = l.cnt + 1'b1;
               if (l.cnt == LAST_FRAME_BIT) begin
                  m.frame = link_frame_s'(m.shift);
                  m.req_tgl = ~l.req_tgl;
                  m.cnt = '0;
                  m.state = LS_WAIT;
                  m.oe = 1'b1;
                  m.dout = 1'b0;
               end
            end
            LS_WAIT: begin
               if (ack_l == l.req_tgl) begin
                  m.dout = 1'b1;
                  m.rsh = r.reply;
                  m.state = LS_REPLY;
               end
            end
            LS_REPLY: begin
               m.dout = l.rsh[7];
               m.rsh = {l.rsh[6:0], 1'b0};
               m.cnt = l.cnt + 1'b1;
               if (l.cnt == LAST_REPLY_BIT) begin
                  m.state = LS_DONE;
               end
            end
            LS_DONE: begin
               m.oe = 1'b0;
               m.dout = 1'b0;
            end
            default: begin
               m.state = LS_SHIFT;
            end
         endcase
      end
   end

   // link state register
   always_ff @(posedge prog_link_clock) begin
      l <= m;
   end

   // outputs straight from state flops
   assign prog_link_data_out = l.dout;
   assign prog_link_data_oe = l.oe;
   assign iap_done = r.iap_done;
   assign iap_status = r.iap_status;
   assign flash_stb = r.stb;
   assign flash_op = r.op;
   assign prog_mode = r.mode;
   assign readout_protected = r.prot;

   // helper: unlocked tool request that must be issued
   logic tool_go;
   assign tool_go = r.state == ST_IDLE && link_new && r.mode != MODE_IAP && r.lock == LOCK_OPEN && !r.prot
                    && link_op.kind == OP_ERASE_SECTOR && {1'b0, link_op.addr} >= FLASH_BASE;

   sequence wipe_done_s;
      r.state == ST_WIPE && flash_done;
   endsequence

   sequence option_issue_s;
      r.stb && r.op.kind == OP_OPTION && r.state == ST_WAIT;
   endsequence

   byte_write_a: assert property (@(posedge clock) disable iff (rst)
      r.stb && r.op.kind == OP_PROGRAM |-> r.state == ST_WAIT ##1 !r.stb)
      else $error("program strobe not single");
   tool_reach_a: assert property (@(posedge clock) disable iff (rst)
      tool_go |=> r.stb && r.op.kind == OP_ERASE_SECTOR)
      else $error("tool sector erase not issued");
   vector_guard_a: assert property (@(posedge clock) disable iff (rst)
      r.stb && $past(r.mode) == MODE_IAP && (r.op.kind == OP_PROGRAM || r.op.kind == OP_ERASE_SECTOR)
      |-> sector_of(r.op.addr) != SECTOR_VECT)
      else $error("sector zero touched in application mode");
   sector_range_a: assert property (@(posedge clock) disable iff (rst)
      r.stb && r.op.kind == OP_PROGRAM |-> {1'b0, r.op.addr} >= FLASH_BASE)
      else $error("program below flash base");
   erase_align_a: assert property (@(posedge clock) disable iff (rst)
      r.stb && r.op.kind == OP_ERASE_SECTOR |-> r.op.addr == sector_base(sector_of(r.op.addr)))
      else $error("sector erase address not aligned");
   protect_block_a: assert property (@(posedge clock) disable iff (rst)
      r.stb && r.src_link && $past(r.prot) |-> r.op.kind != OP_READ && r.op.kind != OP_PROGRAM
      && r.op.kind != OP_ERASE_SECTOR)
      else $error("protected array reached from link");
   wipe_first_a: assert property (@(posedge clock) disable iff (rst)
      wipe_done_s |=> option_issue_s)
      else $error("option not written after mass erase");
   unlock_gate_a: assert property (@(posedge clock) disable iff (rst)
      r.stb && r.op.kind != OP_READ && $past(r.state) == ST_IDLE
      |-> $past(r.lock) == LOCK_OPEN && r.lock == LOCK_CLOSED)
      else $error("write issued while locked");
   link_release_a: assert property (@(posedge prog_link_clock) disable iff (lrst)
      !prog_select_vpp |=> !prog_link_data_oe)
      else $error("data pin driven outside frame");
endmodule : flash_access_guard
`default_nettype wire

// ### sim/prog_tool_model.sv
// programming tool stand-in on the three-pin link
`timescale 1ns/100ps
`default_nettype none
module prog_tool_model import flash_access_pkg::*; (
   output logic prog_link_clock,
   output logic prog_select_vpp,
   output logic tool_data,
   output logic tool_oe,
   output logic [7:0] reply_byte,
   output logic reply_stb,
   input wire logic pin_level,
   input wire logic dev_oe
);
   // link idles with clock still and select low
   initial begin
      prog_link_clock = 1'b0;
      prog_select_vpp = 1'b0;
      tool_data = 1'b0;
      tool_oe = 1'b0;
      reply_byte = 8'h00;
      reply_stb = 1'b0;
   end

   // one 6 ns link cycle, optionally stretched low
   task automatic tick(input bit slow);
      #3 prog_link_clock = 1'b1;
      #3 prog_link_clock = 1'b0;
      if (slow) #21;
   endtask : tick

   // clock pulses with no frame, used around reset
   task automatic idle(input int n);
      for (int i = 0; i < n; i++) tick(1'b0);
   endtask : idle

   // one frame: 32 bits out, wait for start bit, 8 reply bits in
   task automatic frame(input link_frame_s f, input bit slow, output bit ok);
      int w;
      w = 0;
      prog_select_vpp = 1'b1;
      tool_oe = 1'b1;
      for (int i = 31; i >= 0; i--) begin
         tool_data = f[i];
         tick(slow);
      end
      tool_oe = 1'b0;
      while (pin_level !== 1'b1 && w < 400) begin
         tick(slow);
         w++;
      end
      for (int i = 7; i >= 0; i--) begin
         tick(slow);
         reply_byte[i] = pin_level;
      end
      tick(slow);
      ok = (w < 400) && (dev_oe === 1'b0);
      reply_stb = 1'b1;
      #1 reply_stb = 1'b0;
      prog_select_vpp = 1'b0;
      tick(1'b0);
   endtask : frame
endmodule : prog_tool_model
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench: application port, link tool, flash array stand-in
`timescale 1ns/100ps
`default_nettype none
module tb_top import flash_access_pkg::*;;
   localparam int KB = 16;
   localparam logic [15:0] REST_BASE = 16'(ADDR_SPAN - 17'(KB * KBYTE));
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic strap = 1'b0;
   logic iap_valid = 1'b0;
   logic flash_done = 1'b0;
   logic [7:0] flash_rdata = 8'h00;
   logic [7:0] option_byte = 8'h00;
   flash_op_s iap_op = '0;
   logic [31:0] seed = 32'h6d58ee06;
   logic last_pin = 1'b0;
   int bad_count = 0;
   int n_tests = 0;
   logic [7:0] exp_q[$];
   flash_op_s fop_q[$];
   logic link_clk, sel, tool_data, tool_oe, d_out, d_oe, iap_done, flash_stb, prot, reply_stb;
   logic [7:0] iap_status, reply_byte;
   flash_op_s flash_op;
   prog_mode_e prog_mode;
   // released pin shows the inverse of its last level
   wire logic pin = d_oe ? d_out : (tool_oe ? tool_data : ~last_pin);

   // main oscillator supplied by the bench
   initial forever #4 clock = ~clock;
   always @(posedge link_clk) last_pin <= pin;

   flash_access_guard #(.FLASH_KBYTES(KB)) dut (.clock(clock), .rst(rst), .offboard_strap(strap),
      .prog_link_clock(link_clk), .prog_select_vpp(sel), .prog_link_data_in(pin),
      .prog_link_data_out(d_out), .prog_link_data_oe(d_oe), .iap_valid(iap_valid), .iap_op(iap_op),
      .iap_done(iap_done), .iap_status(iap_status), .flash_stb(flash_stb), .flash_op(flash_op),
      .flash_done(flash_done), .flash_rdata(flash_rdata), .option_byte(option_byte),
      .prog_mode(prog_mode), .readout_protected(prot));
   prog_tool_model tool (.prog_link_clock(link_clk), .prog_select_vpp(sel), .tool_data(tool_data),
      .tool_oe(tool_oe), .reply_byte(reply_byte), .reply_stb(reply_stb), .pin_level(pin), .dev_oe(d_oe));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   task automatic fail_wait();
      check("answer wait", 16'h1, 16'h0);
      complete_run();
   endtask : fail_wait

   task automatic got_reply(input logic [7:0] r);
      check("reply", exp_q.size() != 0 ? {8'h00, exp_q.pop_front()} : 16'hffff, {8'h00, r});
   endtask : got_reply

   // replies from either port are matched against the oldest note
   always @(negedge clock) if (iap_done === 1'b1) got_reply(iap_status);
   always @(posedge reply_stb) got_reply(reply_byte);

   // flash array stand-in: checks each strobe, answers after a random wait
   initial begin
      flash_op_s f;
      flash_op_s e;
      logic [31:0] r;
      forever begin
         @(negedge clock);
         if (flash_stb === 1'b1) begin
            f = flash_op;
            r = xs();
            e = fop_q.size() != 0 ? fop_q.pop_front() : '{OP_NONE, 16'h0, 8'h0};
            check("op kind", 16'(e.kind), 16'(f.kind));
            if (e.kind inside {OP_READ, OP_PROGRAM, OP_ERASE_SECTOR}) check("op addr", e.addr, f.addr);
            if (e.kind inside {OP_PROGRAM, OP_OPTION}) check("op data", 16'(e.data), 16'(f.data));
            repeat (r[1:0]) @(posedge clock);
            @(posedge clock);
            flash_done <= 1'b1;
            flash_rdata <= f.addr[7:0] ^ 8'h3c;
            if (f.kind == OP_OPTION) option_byte <= f.data;
            @(posedge clock);
            flash_done <= 1'b0;
         end
      end
   end

   // one request on the link or the application port
   task automatic req(input bit link, input logic [7:0] cmd, input logic [15:0] a, input logic [7:0] d,
                      input logic [7:0] exp, input bit runs, input logic [15:0] fa);
      int w;
      bit ok;
      logic [31:0] r;
      exp_q.push_back(exp);
      if (runs) fop_q.push_back('{op_kind_e'(cmd[2:0]), fa, d});
      if (link) begin
         r = xs();
         tool.frame('{cmd, a, d}, r[0], ok);
         if (!ok) fail_wait();
      end else begin
         @(posedge clock);
         iap_valid <= 1'b1;
         iap_op <= '{op_kind_e'(cmd[2:0]), a, d};
         w = 0;
         // answer seen as sampled at the edge, request dropped on that edge
         do begin
            @(posedge clock);
            w++;
         end while (iap_done !== 1'b1 && w < 200);
         iap_valid <= 1'b0;
         if (w >= 200) fail_wait();
         @(posedge clock);
      end
   endtask : req

   task automatic unlock(input bit link);
      req(link, 8'h06, 16'h0, KEY_FIRST, RPL_OK, 1'b0, 16'h0);
      req(link, 8'h06, 16'h0, KEY_SECOND, RPL_OK, 1'b0, 16'h0);
   endtask : unlock

   // main sequence
   initial begin
      logic [31:0] r;
      logic [7:0] dcmd[4];
      logic [15:0] dadr[4];
      dcmd = '{8'h02, 8'h03, 8'h04, 8'h05};
      dadr = '{16'hf000, 16'hfffe, 16'he000, 16'h0000};
      // link side sees reset while the system clock counts it out
      fork
         tool.idle(6);
         repeat (16) @(posedge clock);
      join
      rst <= 1'b0;
      tool.idle(4);
      repeat (4) @(posedge clock);
      #1;
      check("mode", 16'(MODE_IAP), 16'(prog_mode));
      // application side
      req(1'b0, 8'h02, 16'he010, 8'h11, RPL_LOCKED, 1'b0, 16'h0);
      req(1'b0, 8'h06, 16'h0, KEY_FIRST, RPL_OK, 1'b0, 16'h0);
      req(1'b0, 8'h06, 16'h0, 8'h33, RPL_BAD, 1'b0, 16'h0);
      r = xs();
      unlock(1'b0);
      req(1'b0, 8'h02, 16'he000, r[7:0], RPL_OK, 1'b1, 16'he000);
      unlock(1'b0);
      req(1'b0, 8'h03, 16'hd123, 8'h00, RPL_OK, 1'b1, REST_BASE);
      // a refusal leaves the lock open, so a wrong key closes it again
      for (int i = 0; i < 4; i++) begin
         unlock(1'b0);
         req(1'b0, dcmd[i], dadr[i], 8'h00, RPL_DENIED, 1'b0, 16'h0);
         req(1'b0, 8'h06, 16'h0, 8'h00, RPL_BAD, 1'b0, 16'h0);
      end
      req(1'b0, 8'h01, 16'he055, 8'h00, 8'h55 ^ 8'h3c, 1'b1, 16'he055);
      // off-board tool on the link
      strap <= 1'b1;
      repeat (5) @(posedge clock);
      #1;
      check("mode", 16'(MODE_OFFBOARD), 16'(prog_mode));
      unlock(1'b1);
      req(1'b1, 8'h03, 16'hf800, 8'h00, RPL_OK, 1'b1, SECTOR0_BASE);
      unlock(1'b1);
      req(1'b1, 8'h02, 16'hfffe, r[15:8], RPL_OK, 1'b1, 16'hfffe);
      unlock(1'b1);
      req(1'b1, 8'h04, 16'h0, 8'h00, RPL_OK, 1'b1, 16'h0);
      req(1'b1, 8'h01, 16'hfff0, 8'h00, 8'hcc, 1'b1, 16'hfff0);
      req(1'b1, 8'h07, 16'h0, 8'h00, RPL_BAD, 1'b0, 16'h0);
      // protection set through an option write on the link
      unlock(1'b1);
      req(1'b1, 8'h05, 16'h0, 8'h01, RPL_OK, 1'b1, 16'h0);
      repeat (3) @(posedge clock);
      #1;
      check("protect", 16'h1, {15'h0, prot});
      req(1'b1, 8'h01, 16'hfff0, 8'h00, RPL_DENIED, 1'b0, 16'h0);
      unlock(1'b1);
      req(1'b1, 8'h02, 16'he000, 8'h12, RPL_DENIED, 1'b0, 16'h0);
      req(1'b1, 8'h06, 16'h0, 8'h00, RPL_BAD, 1'b0, 16'h0);
      unlock(1'b1);
      fop_q.push_back('{OP_ERASE_ALL, 16'h0, 8'h00});
      req(1'b1, 8'h05, 16'h0, 8'hfe, RPL_OK, 1'b1, 16'h0);
      repeat (3) @(posedge clock);
      #1;
      check("protect", 16'h0, {15'h0, prot});
      // in-circuit mode: strap low, select high, sector zero reachable
      @(posedge clock);
      strap <= 1'b0;
      repeat (5) @(posedge clock);
      unlock(1'b1);
      req(1'b1, 8'h02, 16'hf010, r[23:16], RPL_OK, 1'b1, 16'hf010);
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
